// *** verification/qct_trim_regs_tb.sv ***
// self-checking testbench for the q-channel trim register bank
`timescale 1ns/1ps
`include "qct_regs.svh"
module qct_trim_regs_tb;
  import qct_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic scs_n = 1'b1;
  logic sclk = 1'b0;
  logic sdi = 1'b0;
  logic [5:0] fine = 6'h00;
  logic sdo, ofs_sign, sel, dcc;
  logic [11:0] ofs_mag, cd_code;
  logic [14:0] fs_mag;
  logic [5:0] fine_code;
  int err_count = 0;
  int check_count = 0;

  qct_trim_regs qct_trim_regs_inst (.i_clk_sys(clk_sys), .i_rstn(rstn), .i_scs_n(scs_n),
    .i_sclk(sclk), .i_sdi(sdi), .i_fine_delay_magnitude(fine), .o_sdo(sdo),
    .o_q_offset_sign(ofs_sign), .o_q_offset_magnitude(ofs_mag),
    .o_q_fullscale_magnitude(fs_mag), .o_coarse_delay_code(cd_code),
    .o_fine_delay_code(fine_code), .o_aperture_adjust_select(sel),
    .o_duty_cycle_correct(dcc));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // compare and closing
  task automatic check_reg(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: read %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_out(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: output %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // serial frames, slow sclk keeps well above the sync limit
  task automatic xfer(input logic [23:0] f, input int nb, output logic [15:0] rd);
    rd = 16'h0000;
    scs_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    for (int i = 0; i < nb; i++) begin
      sdi = f[23-i];
      repeat (6) @(negedge clk_sys);
      if (i >= 8) rd[23-i] = sdo;
      sclk = 1'b1;
      repeat (6) @(negedge clk_sys);
      sclk = 1'b0;
    end
    // opposite of last bit, so a stale data line is not mistaken
    sdi = ~sdi;
    scs_n = 1'b1;
    repeat (6) @(negedge clk_sys);
  endtask

  // reserved bits always sent as zero by callers
  task automatic wr(input qct_addr_t a, input qct_word_t d);
    logic [15:0] unused;
    xfer({1'b0, 3'b000, a, d}, 24, unused);
  endtask

  task automatic rd_chk(input qct_addr_t a, input qct_word_t exp, input string what);
    logic [15:0] r;
    xfer({1'b1, 3'b000, a, 16'hA5A5}, 24, r);
    check_reg(r, exp, what);
  endtask

  task automatic outs(input logic s, input logic [11:0] m, input logic [14:0] f,
      input logic [11:0] c, input logic [5:0] fn, input logic se, input logic dc);
    check_out({15'h0000, ofs_sign}, {15'h0000, s}, "sign");
    check_out({4'h0, ofs_mag}, {4'h0, m}, "offset");
    check_out({1'b0, fs_mag}, {1'b0, f}, "fullscale");
    check_out({4'h0, cd_code}, {4'h0, c}, "coarse");
    check_out({10'h000, fine_code}, {10'h000, fn}, "fine");
    check_out({14'h0000, sel, dcc}, {14'h0000, se, dc}, "select dcc");
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset_values();
    outs(1'b0, 12'h000, 15'h4000, 12'h000, 6'h00, 1'b0, 1'b1);
    check_out({15'h0000, sdo}, 16'h0000, "sdo idle");
    rd_chk(`QCT_ADDR_OFFSET, 16'h0000, "offset");
    rd_chk(`QCT_ADDR_FULLSCALE, 16'h4000, "fullscale");
    rd_chk(`QCT_ADDR_COARSE, 16'h0004, "coarse");
  endtask

  task automatic t_offset();
    wr(`QCT_ADDR_OFFSET, 16'h1800);
    outs(1'b1, 12'h800, 15'h4000, 12'h000, 6'h00, 1'b0, 1'b1);
    wr(`QCT_ADDR_OFFSET, 16'h0FFF);
    outs(1'b0, 12'hFFF, 15'h4000, 12'h000, 6'h00, 1'b0, 1'b1);
    rd_chk(`QCT_ADDR_OFFSET, 16'h0FFF, "offset");
  endtask

  task automatic t_fullscale();
    wr(`QCT_ADDR_FULLSCALE, 16'h7FFF);
    outs(1'b0, 12'hFFF, 15'h7FFF, 12'h000, 6'h00, 1'b0, 1'b1);
    rd_chk(`QCT_ADDR_FULLSCALE, 16'h7FFF, "fullscale");
  endtask

  task automatic t_coarse();
    logic [11:0] code [4] = '{12'h97F, 12'h980, 12'hFFF, 12'h001};
    logic [11:0] exp [4] = '{12'h97F, 12'h97F, 12'h97F, 12'h001};
    // no dual-edge mode or fast sample clock here, so top codes are safe
    fine = 6'h2A;
    for (int i = 0; i < 4; i++) begin
      wr(`QCT_ADDR_COARSE, {code[i], 4'h8});
      outs(1'b0, 12'hFFF, 15'h7FFF, exp[i], 6'h2A, 1'b1, 1'b0);
    end
    fine = 6'h3F;
    repeat (4) @(negedge clk_sys);
    outs(1'b0, 12'hFFF, 15'h7FFF, 12'h001, 6'h3F, 1'b1, 1'b0);
    rd_chk(`QCT_ADDR_COARSE, 16'h0018, "coarse");
    // select cleared: neither delay may reach the clock path
    wr(`QCT_ADDR_COARSE, 16'h97F4);
    outs(1'b0, 12'hFFF, 15'h7FFF, 12'h000, 6'h00, 1'b0, 1'b1);
  endtask

  task automatic t_refused();
    logic [15:0] unused;
    wr(4'h9, 16'h1234);
    rd_chk(4'h9, 16'h0000, "unmapped");
    // aborted write must leave the register untouched
    xfer({1'b0, 3'b000, `QCT_ADDR_FULLSCALE, 16'h0001}, 20, unused);
    rd_chk(`QCT_ADDR_FULLSCALE, 16'h7FFF, "fullscale");
    rd_chk(`QCT_ADDR_OFFSET, 16'h0FFF, "offset");
  endtask

  task automatic t_second_reset();
    rstn = 1'b0;
    repeat (2) @(negedge clk_sys);
    outs(1'b0, 12'h000, 15'h4000, 12'h000, 6'h00, 1'b0, 1'b1);
    rstn = 1'b1;
    repeat (3) @(negedge clk_sys);
    rd_chk(`QCT_ADDR_COARSE, 16'h0004, "coarse");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_reset_values();
    t_offset();
    t_fullscale();
    t_coarse();
    t_refused();
    t_second_reset();
    report_and_stop();
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    $display("CHECK FAILED at %0t: run limit reached", $time);
    report_and_stop();
  end
endmodule

// *** verilog/qct_cfg_if.sv ***
// register access signals between serial port and register bank
`timescale 1ns/1ps
interface qct_cfg_if;
  import qct_pkg::*;
  logic wr_en;
  qct_addr_t addr;
  qct_word_t wdata;
  qct_word_t rdata;
  modport port (output wr_en, output addr, output wdata, input rdata);
  modport regs (input wr_en, input addr, input wdata, output rdata);
endinterface

// *** verilog/qct_pkg.sv ***
// types shared by the q-channel trim register bank
package qct_pkg;
  typedef logic [3:0] qct_addr_t;
  typedef logic [15:0] qct_word_t;
  typedef logic [11:0] qct_delay_t;
endpackage

// *** verilog/qct_regs.svh ***
// constants for the q-channel trim and aperture delay register bank
// How it works
// (RQ1) host writes zero to every reserved bit of the three registers
// (RQ2) offset sign bit 12 low gives positive offset, high negative
// (RQ3) offset magnitude is straight binary, zero to about 45 mV
// (RQ4) 15-bit full-scale code sets range, midscale 800 mV, all ones 1000 mV
// (RQ5) coarse code delays sampling clock, 0 ps to 825 ps at 2431
// (RQ6) coarse codes 2432 and above hold delay at its maximum
// (RQ7) coarse and fine delays only take effect while adjust select is set
// (RQ8) duty-cycle stabilizer enabled while bit 2 is set, its default
// (RQ9) host avoids delay adjust in dual-edge modes above 1600 MHz clock
// (RQ10) host should avoid maximum delay at the highest sampling rate
// (RQ11) with adjust selected a 6-bit fine delay is added, up to 2.3 ps
// (RQ12) a read returns the last written value or the power-on value
`ifndef QCT_REGS_SVH
`define QCT_REGS_SVH

// ==========================================================
// register map
`define QCT_ADDR_OFFSET 4'hA
`define QCT_ADDR_FULLSCALE 4'hB
`define QCT_ADDR_COARSE 4'hC
`define QCT_RST_OFFSET 16'h0000
`define QCT_RST_FULLSCALE 16'h4000
`define QCT_RST_COARSE 16'h0004

// ==========================================================
// field positions
`define QCT_OFS_SIGN_BIT 12
`define QCT_OFS_MAG_MSB 11
`define QCT_FS_MAG_MSB 14
`define QCT_CD_MAG_MSB 15
`define QCT_CD_MAG_LSB 4
`define QCT_CD_SEL_BIT 3
`define QCT_CD_DCC_BIT 2
`define QCT_CD_MAX_CODE 12'h97F
`define QCT_FINE_WIDTH 6

// ==========================================================
// serial frame: read flag, three spare bits, address, data
`define QCT_FRAME_BITS 5'h18
`define QCT_HDR_BITS 5'h08
`define QCT_RW_BIT 7

`endif

// *** verilog/qct_serial_port.sv ***
// serial control port: pin synchroniser, frame shifter, read data out
`timescale 1ns/1ps
`include "qct_regs.svh"
module qct_serial_port
  import qct_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_scs_n,
  input wire logic i_sclk,
  input wire logic i_sdi,
  output logic o_sdo,
  qct_cfg_if.port cfg
);
  // ==========================================================
  // synchroniser, pins are asynchronous to the system clock
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic sclk_d;
  logic [4:0] cnt;
  logic [23:0] sh;
  logic [15:0] out;
  logic rd;
  logic wr;
  logic load;
  logic next_load;
  qct_addr_t addr;
  logic [4:0] next_cnt;
  logic [23:0] next_sh;
  logic [15:0] next_out;
  logic next_rd;
  logic next_wr;
  qct_addr_t next_addr;
  logic rise;
  logic fall;
  logic active;

  assign active = ~sync2[2];
  assign rise = sync2[1] & ~sclk_d;
  assign fall = ~sync2[1] & sclk_d;

  // ==========================================================
  // frame decode
  always_comb begin
    next_cnt = cnt;
    next_sh = sh;
    next_out = out;
    next_rd = rd;
    next_wr = 1'b0;
    next_load = 1'b0;
    next_addr = addr;
    if (!active) begin
      next_cnt = 5'h00;
      next_rd = 1'b0;
      next_out = 16'h0000;
    end else if (rise && cnt != `QCT_FRAME_BITS) begin
      next_sh = {sh[22:0], sync2[0]};
      next_cnt = cnt + 5'h01;
      if (cnt == `QCT_HDR_BITS - 5'h01) begin
        next_addr = next_sh[3:0];
        next_rd = next_sh[`QCT_RW_BIT];
        // fetch waits a cycle, the bank still decodes the old address now
        next_load = next_sh[`QCT_RW_BIT];
      end
      if (cnt == `QCT_FRAME_BITS - 5'h01 && !rd) begin
        next_wr = 1'b1;
      end
    end else if (load) begin
      // read data captured once, so the word is coherent
      next_out = cfg.rdata;
    end else if (fall && rd && cnt > `QCT_HDR_BITS) begin
      next_out = {out[14:0], 1'b0};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      // idle pin levels, so no false clock edge follows reset
      sync1 <= 3'h4;
      sync2 <= 3'h4;
      sclk_d <= 1'b0;
      cnt <= 5'h00;
      sh <= 24'h000000;
      out <= 16'h0000;
      rd <= 1'b0;
      wr <= 1'b0;
      load <= 1'b0;
      addr <= 4'h0;
    end else begin
      sync1 <= {i_scs_n, i_sclk, i_sdi};
      sync2 <= sync1;
      sclk_d <= sync2[1];
      cnt <= next_cnt;
      sh <= next_sh;
      out <= next_out;
      rd <= next_rd;
      wr <= next_wr;
      load <= next_load;
      addr <= next_addr;
    end
  end

  assign o_sdo = out[15];
  assign cfg.wr_en = wr;
  assign cfg.addr = addr;
  assign cfg.wdata = sh[15:0];
endmodule

// *** verilog/qct_trim_regs.sv ***
// q-channel offset, full-scale and aperture delay register bank
`timescale 1ns/1ps
`include "qct_regs.svh"
module qct_trim_regs
  import qct_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_scs_n,
  input wire logic i_sclk,
  input wire logic i_sdi,
  input wire logic [5:0] i_fine_delay_magnitude,
  output logic o_sdo,
  output logic o_q_offset_sign,
  output logic [11:0] o_q_offset_magnitude,
  output logic [14:0] o_q_fullscale_magnitude,
  output logic [11:0] o_coarse_delay_code,
  output logic [5:0] o_fine_delay_code,
  output logic o_aperture_adjust_select,
  output logic o_duty_cycle_correct
);
  qct_cfg_if cfg ();

  qct_serial_port qct_serial_port_inst (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_scs_n(i_scs_n),
    .i_sclk(i_sclk),
    .i_sdi(i_sdi),
    .o_sdo(o_sdo),
    .cfg(cfg)
  );

  // ==========================================================
  // register storage
  qct_word_t q_offset_trim;
  qct_word_t q_fullscale_trim;
  qct_word_t aperture_coarse_delay;
  qct_word_t next_q_offset_trim;
  qct_word_t next_q_fullscale_trim;
  qct_word_t next_aperture_coarse_delay;

  function automatic qct_word_t read_word(input qct_addr_t a, input qct_word_t o,
                                          input qct_word_t f, input qct_word_t c);
    unique case (a)
      `QCT_ADDR_OFFSET: read_word = o;
      `QCT_ADDR_FULLSCALE: read_word = f;
      `QCT_ADDR_COARSE: read_word = c;
      default: read_word = 16'h0000;
    endcase
  endfunction

  // (RQ12) stored as written
  always_comb begin
    next_q_offset_trim = q_offset_trim;
    next_q_fullscale_trim = q_fullscale_trim;
    next_aperture_coarse_delay = aperture_coarse_delay;
    if (cfg.wr_en) begin
      // reserved bits kept as written so a read echoes the host
      if (cfg.addr == `QCT_ADDR_OFFSET) begin
        next_q_offset_trim = cfg.wdata;
      end
      if (cfg.addr == `QCT_ADDR_FULLSCALE) begin
        next_q_fullscale_trim = cfg.wdata;
      end
      if (cfg.addr == `QCT_ADDR_COARSE) begin
        next_aperture_coarse_delay = cfg.wdata;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      q_offset_trim <= `QCT_RST_OFFSET;
      q_fullscale_trim <= `QCT_RST_FULLSCALE;
      aperture_coarse_delay <= `QCT_RST_COARSE;
    end else begin
      q_offset_trim <= next_q_offset_trim;
      q_fullscale_trim <= next_q_fullscale_trim;
      aperture_coarse_delay <= next_aperture_coarse_delay;
    end
  end

  // (RQ12) read back mux
  assign cfg.rdata = read_word(cfg.addr, q_offset_trim, q_fullscale_trim,
                               aperture_coarse_delay);

  // ==========================================================
  // trim controls toward the analog side
  qct_delay_t cam;
  logic sel;
  logic next_sign;
  logic [11:0] next_ofs_mag;
  logic [14:0] next_fs_mag;
  qct_delay_t next_coarse;
  logic [5:0] next_fine;
  logic next_sel;
  logic next_dcc;

  assign cam = aperture_coarse_delay[`QCT_CD_MAG_MSB:`QCT_CD_MAG_LSB];
  assign sel = aperture_coarse_delay[`QCT_CD_SEL_BIT];

  always_comb begin
    // (RQ2) sign, low means positive
    next_sign = q_offset_trim[`QCT_OFS_SIGN_BIT];
    // (RQ3) straight binary magnitude
    next_ofs_mag = q_offset_trim[`QCT_OFS_MAG_MSB:0];
    // (RQ4) full-scale code
    next_fs_mag = q_fullscale_trim[`QCT_FS_MAG_MSB:0];
    next_sel = sel;
    // (RQ8) stabilizer enable
    next_dcc = aperture_coarse_delay[`QCT_CD_DCC_BIT];
    next_coarse = 12'h000;
    next_fine = 6'h00;
    // (RQ7) delays gated by select
    if (sel) begin
      // (RQ5) (RQ6) coarse code, saturating at the maximum
      next_coarse = (cam > `QCT_CD_MAX_CODE) ? `QCT_CD_MAX_CODE : cam;
      // (RQ11) fine delay added when selected
      next_fine = i_fine_delay_magnitude;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_q_offset_sign <= 1'b0;
      o_q_offset_magnitude <= 12'h000;
      o_q_fullscale_magnitude <= 15'h4000;
      o_coarse_delay_code <= 12'h000;
      o_fine_delay_code <= 6'h00;
      o_aperture_adjust_select <= 1'b0;
      o_duty_cycle_correct <= 1'b1;
    end else begin
      o_q_offset_sign <= next_sign;
      o_q_offset_magnitude <= next_ofs_mag;
      o_q_fullscale_magnitude <= next_fs_mag;
      o_coarse_delay_code <= next_coarse;
      o_fine_delay_code <= next_fine;
      o_aperture_adjust_select <= next_sel;
      o_duty_cycle_correct <= next_dcc;
    end
  end

  // ==========================================================
  // checks
  a_offset_sign_write: assert property ( // RQ2
    @(posedge i_clk_sys) disable iff (!i_rstn)
    cfg.wr_en && cfg.addr == `QCT_ADDR_OFFSET |=> ##1 o_q_offset_sign == $past(cfg.wdata[12], 2))
    else $error("offset sign does not follow write");
  a_offset_mag_write: assert property ( // RQ3
    @(posedge i_clk_sys) disable iff (!i_rstn)
    cfg.wr_en && cfg.addr == `QCT_ADDR_OFFSET |-> ##2 o_q_offset_magnitude == $past(cfg.wdata[11:0], 2))
    else $error("offset magnitude does not follow write");
  a_fullscale_write: assert property ( // RQ4
    @(posedge i_clk_sys) disable iff (!i_rstn)
    cfg.wr_en && cfg.addr == `QCT_ADDR_FULLSCALE |-> ##2 o_q_fullscale_magnitude == $past(cfg.wdata[14:0], 2))
    else $error("full-scale code does not follow write");
  a_coarse_pass: assert property ( // RQ5
    @(posedge i_clk_sys) disable iff (!i_rstn)
    sel && cam <= 12'h97F |=> o_coarse_delay_code == $past(cam))
    else $error("coarse delay code not applied");
  a_coarse_sat: assert property ( // RQ6
    @(posedge i_clk_sys) disable iff (!i_rstn)
    sel && cam >= 12'h980 |=> o_coarse_delay_code == 12'h97F)
    else $error("coarse delay not saturated");
  a_delay_gated: assert property ( // RQ7
    @(posedge i_clk_sys) disable iff (!i_rstn)
    !sel |=> o_coarse_delay_code == 12'h000 && o_fine_delay_code == 6'h00)
    else $error("delay applied without select");
  a_dcc_write: assert property ( // RQ8
    @(posedge i_clk_sys) disable iff (!i_rstn)
    cfg.wr_en && cfg.addr == `QCT_ADDR_COARSE |-> ##2 o_duty_cycle_correct == $past(cfg.wdata[2], 2))
    else $error("duty cycle enable does not follow write");
  a_fine_pass: assert property ( // RQ11
    @(posedge i_clk_sys) disable iff (!i_rstn)
    sel |=> o_fine_delay_code == $past(i_fine_delay_magnitude))
    else $error("fine delay not applied");
  a_read_back: assert property ( // RQ12
    @(posedge i_clk_sys) disable iff (!i_rstn)
    cfg.wr_en && cfg.addr >= `QCT_ADDR_OFFSET && cfg.addr <= `QCT_ADDR_COARSE |=>
      read_word($past(cfg.addr), q_offset_trim, q_fullscale_trim, aperture_coarse_delay)
        == $past(cfg.wdata))
    else $error("read back differs from written word");

  // ==========================================================
  // write-path checks seen from the bus side

  // (RQ7) select follows write
  a_select_write: assert property ( // RQ7
    @(posedge i_clk_sys) disable iff (!i_rstn)
    cfg.wr_en && cfg.addr == `QCT_ADDR_COARSE |-> ##2
      o_aperture_adjust_select == $past(cfg.wdata[`QCT_CD_SEL_BIT], 2))
    else $error("adjust select does not follow write");

  // (RQ5) written code applied
  a_coarse_write: assert property ( // RQ5
    @(posedge i_clk_sys) disable iff (!i_rstn)
    cfg.wr_en && cfg.addr == `QCT_ADDR_COARSE && cfg.wdata[`QCT_CD_SEL_BIT] &&
      cfg.wdata[`QCT_CD_MAG_MSB:`QCT_CD_MAG_LSB] <= `QCT_CD_MAX_CODE |-> ##2
      o_coarse_delay_code == $past(cfg.wdata[`QCT_CD_MAG_MSB:`QCT_CD_MAG_LSB], 2))
    else $error("written coarse code not applied");

  // (RQ6) written code saturates
  a_coarse_write_sat: assert property ( // RQ6
    @(posedge i_clk_sys) disable iff (!i_rstn)
    cfg.wr_en && cfg.addr == `QCT_ADDR_COARSE && cfg.wdata[`QCT_CD_SEL_BIT] &&
      cfg.wdata[`QCT_CD_MAG_MSB:`QCT_CD_MAG_LSB] >= 12'h980 |-> ##2
      o_coarse_delay_code == `QCT_CD_MAX_CODE)
    else $error("written coarse code not saturated");

  // (RQ7) cleared select gates both
  a_write_gated: assert property ( // RQ7
    @(posedge i_clk_sys) disable iff (!i_rstn)
    cfg.wr_en && cfg.addr == `QCT_ADDR_COARSE && !cfg.wdata[`QCT_CD_SEL_BIT] |-> ##2
      o_coarse_delay_code == 12'h000 && o_fine_delay_code == 6'h00)
    else $error("delay applied after select cleared");

  // (RQ11) fine code passed
  a_fine_write: assert property ( // RQ11
    @(posedge i_clk_sys) disable iff (!i_rstn)
    cfg.wr_en && cfg.addr == `QCT_ADDR_COARSE && cfg.wdata[`QCT_CD_SEL_BIT] |-> ##2
      o_fine_delay_code == $past(i_fine_delay_magnitude))
    else $error("fine code not passed after select set");

  // (RQ12) no change without a write
  a_regs_hold: assert property ( // RQ12
    @(posedge i_clk_sys) disable iff (!i_rstn)
    !cfg.wr_en |=> $stable(q_offset_trim) && $stable(q_fullscale_trim) &&
      $stable(aperture_coarse_delay))
    else $error("register changed without a write");

  // (RQ12) unmapped writes dropped
  a_unmapped_ignored: assert property ( // RQ12
    @(posedge i_clk_sys) disable iff (!i_rstn)
    cfg.wr_en && (cfg.addr < `QCT_ADDR_OFFSET || cfg.addr > `QCT_ADDR_COARSE) |=>
      $stable(q_offset_trim) && $stable(q_fullscale_trim) && $stable(aperture_coarse_delay))
    else $error("unmapped write changed a register");

  // (RQ12) offset write spares others
  a_offset_only: assert property ( // RQ12
    @(posedge i_clk_sys) disable iff (!i_rstn)
    cfg.wr_en && cfg.addr == `QCT_ADDR_OFFSET |=>
      $stable(q_fullscale_trim) && $stable(aperture_coarse_delay))
    else $error("offset write changed another register");
endmodule
